// >>> rtl/ldsf_core.sv
// led drive core: gate drives, soft start sequencing, start-up timer and fault counter
// What this block does
// - drive_a and drive_b run half a switching period apart.
// - resonant mode keeps full duty and shifts frequency with loop error.
// - pwm mode keeps oscillator frequency and sets duty from loop error.
// - sync mode drives a in positive half, b in negative half of sync.
// - sync pulses are leading-edge modulated, ending at the sync zero crossing.
// - aux_drive follows oscillator; leading edge in resonant/sync, trailing edge in pwm.
// - after reset, cap leaves dimming and the small charge source turns on.
// - at cap threshold, charging stops and the pin returns to dimming.
// - after soft start, drives run only while the cap comparator is high.
// - 32k-cycle start-up timer; no minimum current by full count means fault.
// - open-led detection is held off until the start-up timer completes.
// - after start-up, led on with low current counts faults; 256 confirms.
// - fault counter ticks at oscillator rate and clears every 32768 ticks.
// - any current above minimum while open-led counting clears the counter.
// - over-current counts the fault counter; 256 reports a fault.
// - over-current status held about 50 us; counter clears if then gone.
// - short circuit disables all drives at once and raises the fault.
// - short-circuit detection is live from reset release, even in soft start.
// - over-voltage clamps loop error down and runs the fault counter.
// - over-voltage uses the same periodic clear and 50 us hold.
// - enable level picks resonant, pwm or synchronous mode.
// - reset clears counters and fault latch and holds drives inactive.
// - sync undervoltage runs the fault counter with the same clear and hold.
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ldsf_core #(
  parameter int CNT_W = 9
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cs_above_min,
  input  wire logic        cs_above_oc,
  input  wire logic        cs_above_sc,
  input  wire logic        vs_above_ov,
  input  wire logic        sync_positive,
  input  wire logic        sync_below_uv,
  input  wire logic        ss_above_thr,
  input  wire logic        enable_above_2v,
  input  wire logic        enable_above_3v,
  input  wire logic        enable_above_4v,
  output logic             drive_a,
  output logic             drive_b,
  output logic             aux_drive,
  output logic             fault_n,
  output logic             ss_charge_on,
  output logic             ss_to_dimming,
  output logic             ov_clamp
);
  // comparator synchronisers
  logic [ldsf_pkg::CMP_N-1:0] cmp_s1;
  logic [ldsf_pkg::CMP_N-1:0] cmp_s2;
  logic [ldsf_pkg::CMP_N-1:0] cmp_s3;
  logic [ldsf_pkg::CMP_N-1:0] cmp;
  wire  [ldsf_pkg::CMP_N-1:0] cmp_raw;
  wire  [ldsf_pkg::CMP_N-1:0] next_cmp;

  assign cmp_raw = {enable_above_4v, enable_above_3v, enable_above_2v, ss_above_thr, sync_below_uv,
                    sync_positive, vs_above_ov, cs_above_sc, cs_above_oc, cs_above_min};
  // a bit changes only once stages two and three agree
  assign next_cmp = ((cmp_s2 ~^ cmp_s3) & cmp_s2) | ((cmp_s2 ^ cmp_s3) & cmp);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_s1 <= '0;
      cmp_s2 <= '0;
      cmp_s3 <= '0;
      cmp    <= '0;
    end else begin
      cmp_s1 <= cmp_raw;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      cmp    <= next_cmp;
    end
  end

  wire cs_min  = cmp[ldsf_pkg::CMP_CS_MIN];
  wire cs_oc   = cmp[ldsf_pkg::CMP_CS_OC];
  wire cs_sc   = cmp[ldsf_pkg::CMP_CS_SC];
  wire vs_ov   = cmp[ldsf_pkg::CMP_VS_OV];
  wire syn_pos = cmp[ldsf_pkg::CMP_SYNPOS];
  wire syn_uv  = cmp[ldsf_pkg::CMP_SYN_UV];
  wire ss_thr  = cmp[ldsf_pkg::CMP_SS_THR];

  // mode select
  ldsf_pkg::ldsf_mode_t mode;
  assign mode = cmp[ldsf_pkg::CMP_EN_4V] ? ldsf_pkg::LDSF_SYNC :
                cmp[ldsf_pkg::CMP_EN_3V] ? ldsf_pkg::LDSF_PWM :
                cmp[ldsf_pkg::CMP_EN_2V] ? ldsf_pkg::LDSF_RESONANT : ldsf_pkg::LDSF_OFF;

  // software registers
  logic [15:0] period_reg;
  logic [15:0] loop_reg;

  // oscillator
  logic [16:0] osc_ctr;
  wire  [16:0] period_base = (period_reg < ldsf_pkg::PERIOD_MIN) ? {1'b0, ldsf_pkg::PERIOD_MIN} : {1'b0, period_reg};
  wire  [16:0] period_eff  = (mode == ldsf_pkg::LDSF_RESONANT) ? period_base + {1'b0, loop_reg} : period_base;
  wire  [16:0] half_per    = {1'b0, period_eff[16:1]};
  wire         osc_tick    = (osc_ctr >= period_eff - 17'd1);
  wire  [16:0] width       = ({1'b0, loop_reg} > half_per) ? half_per : {1'b0, loop_reg};
  wire         first_half  = (osc_ctr < half_per);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_ctr <= '0;
    end else begin
      osc_ctr <= osc_tick ? 17'd0 : osc_ctr + 17'd1;
    end
  end

  // sync half-period measurement
  logic        syn_prev;
  logic [16:0] syn_cnt;
  logic [16:0] syn_last;
  wire         syn_edge  = (syn_prev != syn_pos);
  wire  [16:0] syn_width = (width > syn_last) ? syn_last : width;
  wire  [16:0] syn_start = syn_last - syn_width;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      syn_prev <= 1'b0;
      syn_cnt  <= '0;
      syn_last <= '0;
    end else begin
      syn_prev <= syn_pos;
      syn_cnt  <= syn_edge ? 17'd0 : ((&syn_cnt) ? syn_cnt : syn_cnt + 17'd1);
      if (syn_edge) begin
        syn_last <= syn_cnt;
      end
    end
  end

  // soft start and fault state
  ldsf_pkg::ldsf_state_t state;
  logic        fault;
  logic        sc_seen;
  logic        sufail;
  logic        su_done;
  logic        cs_seen;
  logic [14:0] su_cnt;
  logic [14:0] clr_cnt;
  logic [CNT_W-1:0] fcnt;
  logic [9:0]  hold_cnt [3];

  wire led_on = (state == ldsf_pkg::LDSF_RUN) && ss_thr;
  wire drv_en = led_on && !fault && !cs_sc && (mode != ldsf_pkg::LDSF_OFF);

  // drive waveforms
  wire sync_on   = syn_cnt >= syn_start;
  wire next_a    = (mode == ldsf_pkg::LDSF_SYNC) ? (syn_pos && sync_on) :
                   (mode == ldsf_pkg::LDSF_PWM)  ? (osc_ctr < width) :
                   first_half;
  wire next_b    = (mode == ldsf_pkg::LDSF_SYNC) ? (!syn_pos && sync_on) :
                   (mode == ldsf_pkg::LDSF_PWM)  ? (!first_half && (osc_ctr - half_per) < width) :
                   !first_half;
  wire next_aux  = (mode == ldsf_pkg::LDSF_PWM) ? (osc_ctr < width) :
                   (osc_ctr >= period_eff - width);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_a   <= 1'b0;
      drive_b   <= 1'b0;
      aux_drive <= 1'b0;
    end else begin
      drive_a   <= drv_en && next_a;
      drive_b   <= drv_en && next_b;
      aux_drive <= drv_en && next_aux && (width != 17'd0);
    end
  end

  // fault conditions
  wire [2:0] cond      = {syn_uv, vs_ov, cs_oc};
  logic [2:0] hold_act;
  logic [2:0] hold_exp;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      hold_act[i] = (hold_cnt[i] != 10'd0);
      hold_exp[i] = (hold_cnt[i] == 10'd1) && !cond[i];
    end
  end
  wire open_cond  = su_done && led_on && !cs_min;
  wire count_cond = open_cond || (|hold_act);
  wire open_clear = su_done && cs_min && !(|hold_act);
  wire per_clear  = osc_tick && (clr_cnt == 15'(ldsf_pkg::CLEAR_TICKS - 1));
  wire fcnt_full  = (fcnt == CNT_W'(ldsf_pkg::FAULT_FULL));
  wire su_term    = osc_tick && (su_cnt == 15'(ldsf_pkg::STARTUP_TICKS - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 3; i++) begin
        hold_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (cond[i]) begin
          hold_cnt[i] <= 10'(ldsf_pkg::HOLD_CYC);
        end else if (hold_act[i]) begin
          hold_cnt[i] <= hold_cnt[i] - 10'd1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fcnt    <= '0;
      clr_cnt <= '0;
    end else begin
      if (osc_tick) begin
        clr_cnt <= clr_cnt + 15'd1;
      end
      if (per_clear || (|hold_exp) || open_clear) begin
        fcnt <= '0;
      end else if (osc_tick && count_cond && !fcnt_full) begin
        fcnt <= fcnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      su_cnt  <= '0;
      su_done <= 1'b0;
      cs_seen <= 1'b0;
    end else begin
      if (cs_min) begin
        cs_seen <= 1'b1;
      end
      if (!su_done && osc_tick) begin
        su_cnt <= su_cnt + 15'd1;
      end
      if (su_term && !su_done) begin
        su_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault   <= 1'b0;
      sc_seen <= 1'b0;
      sufail  <= 1'b0;
    end else begin
      if (cs_sc) begin
        fault   <= 1'b1;
        sc_seen <= 1'b1;
      end
      if (su_term && !su_done && !cs_seen && !cs_min) begin
        fault  <= 1'b1;
        sufail <= 1'b1;
      end
      if (fcnt_full) begin
        fault <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state         <= ldsf_pkg::LDSF_SOFTSTART;
      fault_n       <= 1'b1;
      ss_charge_on  <= 1'b0;
      ss_to_dimming <= 1'b0;
      ov_clamp      <= 1'b0;
    end else begin
      unique case (state)
        ldsf_pkg::LDSF_SOFTSTART: begin
          if (ss_thr) begin
            state <= ldsf_pkg::LDSF_RUN;
          end
        end
        ldsf_pkg::LDSF_RUN: begin
          state <= ldsf_pkg::LDSF_RUN;
        end
      endcase
      fault_n       <= !fault;
      ss_charge_on  <= (state == ldsf_pkg::LDSF_SOFTSTART) && !ss_thr;
      ss_to_dimming <= (state == ldsf_pkg::LDSF_RUN) || ss_thr;
      ov_clamp      <= vs_ov;
    end
  end

  // ahb-lite slave, zero wait states
  logic       wr_pend;
  logic [7:0] wr_addr;
  wire        acc     = hsel && hready && htrans[1];
  wire  [7:0] a_addr  = haddr[7:0];
  // count field shows the top eight bits of the fault counter
  wire  [31:0] status = {16'h0000, 8'(fcnt >> (CNT_W - 8)),
                         sufail, sc_seen, mode, led_on, su_done, (state == ldsf_pkg::LDSF_RUN), fault};
  wire  [31:0] rd_mux = (a_addr == ldsf_pkg::OFS_PERIOD) ? {16'h0000, period_reg} :
                        (a_addr == ldsf_pkg::OFS_LOOP)   ? {16'h0000, loop_reg} :
                        (a_addr == ldsf_pkg::OFS_STATUS) ? status :
                        (a_addr == ldsf_pkg::OFS_FCOUNT) ? 32'(fcnt) :
                        (a_addr == ldsf_pkg::OFS_SUTIME) ? {17'h00000, su_cnt} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
    end else begin
      wr_pend <= acc && hwrite;
      if (acc) begin
        wr_addr <= a_addr;
      end
      if (acc && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_reg <= ldsf_pkg::PERIOD_RST;
      loop_reg   <= ldsf_pkg::LOOP_RST;
    end else if (wr_pend) begin
      if (wr_addr == ldsf_pkg::OFS_PERIOD) begin
        period_reg <= hwdata[15:0];
      end
      if (wr_addr == ldsf_pkg::OFS_LOOP) begin
        loop_reg <= hwdata[15:0];
      end
    end
  end

endmodule // ldsf_core
`default_nettype wire

// >>> rtl/ldsf_pkg.sv
// constants and types shared by the led drive / soft start / fault core
package ldsf_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_PERIOD = 8'h00;
  localparam logic [7:0] OFS_LOOP   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FCOUNT = 8'h0C;
  localparam logic [7:0] OFS_SUTIME = 8'h10;
  // reset values and minimum oscillator period
  localparam logic [15:0] PERIOD_RST = 16'h00C8;
  localparam logic [15:0] LOOP_RST   = 16'h0000;
  localparam logic [15:0] PERIOD_MIN = 16'h0004;
  // status field positions
  localparam int ST_FAULT   = 0;
  localparam int ST_RUN     = 1;
  localparam int ST_SUDONE  = 2;
  localparam int ST_LEDON   = 3;
  localparam int ST_MODE    = 4;
  localparam int ST_SC      = 6;
  localparam int ST_SUFAIL  = 7;
  localparam int ST_CNTFLT  = 8;
  // comparator input bit positions
  localparam int CMP_CS_MIN = 0;
  localparam int CMP_CS_OC  = 1;
  localparam int CMP_CS_SC  = 2;
  localparam int CMP_VS_OV  = 3;
  localparam int CMP_SYNPOS = 4;
  localparam int CMP_SYN_UV = 5;
  localparam int CMP_SS_THR = 6;
  localparam int CMP_EN_2V  = 7;
  localparam int CMP_EN_3V  = 8;
  localparam int CMP_EN_4V  = 9;
  localparam int CMP_N      = 10;
  // timing
  localparam int CLK_MHZ       = 20;
  localparam int HOLD_US       = 50;
  localparam int HOLD_CYC      = HOLD_US * CLK_MHZ;
  localparam int STARTUP_TICKS = 32768;
  localparam int CLEAR_TICKS   = 32768;
  localparam int FAULT_FULL    = 256;
  typedef enum logic [1:0] {LDSF_OFF, LDSF_RESONANT, LDSF_PWM, LDSF_SYNC} ldsf_mode_t;
  typedef enum logic {LDSF_SOFTSTART, LDSF_RUN} ldsf_state_t;
endpackage

// >>> dv/ldsf_asserts.sv
// concurrent checks on the led drive core ports
`timescale 1ns/1ps
`default_nettype none
module ldsf_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cs_above_sc,
  input wire logic vs_above_ov,
  input wire logic ss_above_thr,
  input wire logic enable_above_2v,
  input wire logic drive_a,
  input wire logic drive_b,
  input wire logic aux_drive,
  input wire logic fault_n,
  input wire logic ss_charge_on,
  input wire logic ss_to_dimming,
  input wire logic ov_clamp
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire drv_off = !drive_a && !drive_b && !aux_drive;
  property p_apart; !(drive_a && drive_b); endproperty
  a_apart: assert property (p_apart) else $error("both main drives on");
  property p_charge; $past(hresetn) && !ss_to_dimming |-> ss_charge_on; endproperty
  a_charge: assert property (p_charge) else $error("soft start source off");
  property p_handover; ss_to_dimming |-> !ss_charge_on; endproperty
  a_handover: assert property (p_handover) else $error("source on after handover");
  property p_keep; ss_to_dimming |=> ss_to_dimming; endproperty
  a_keep: assert property (p_keep) else $error("handover undone");
  property p_gate; !ss_above_thr [*6] |-> drv_off; endproperty
  a_gate: assert property (p_gate) else $error("drive on with cap low");
  property p_short; cs_above_sc [*6] |-> drv_off ##1 !fault_n; endproperty
  a_short: assert property (p_short) else $error("short circuit not handled");
  property p_latch; !fault_n |=> !fault_n; endproperty
  a_latch: assert property (p_latch) else $error("fault released");
  property p_fault_off; !fault_n ##1 !fault_n |-> drv_off; endproperty
  a_fault_off: assert property (p_fault_off) else $error("drive on in fault");
  property p_clamp; vs_above_ov [*6] |-> ov_clamp; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp missing");
  property p_mode_off; !enable_above_2v [*6] |-> drv_off; endproperty
  a_mode_off: assert property (p_mode_off) else $error("drive on in off mode");
endmodule // ldsf_asserts
bind ldsf_core ldsf_asserts u_chk (.hclk, .hresetn, .cs_above_sc, .vs_above_ov, .ss_above_thr, .enable_above_2v,
  .drive_a, .drive_b, .aux_drive, .fault_n, .ss_charge_on, .ss_to_dimming, .ov_clamp);
`default_nettype wire

// >>> dv/ldsf_partner.sv
// model of the led string switches and soft start capacitor
`timescale 1ns/1ps
`default_nettype none
module ldsf_partner #(
  parameter int CAP_THR = 32
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic drive_a,
  input  wire logic drive_b,
  input  wire logic ss_charge_on,
  input  wire logic dim_low,
  output var  logic cs_above_min,
  output var  logic ss_above_thr
);
  int cap;
  // capacitor discharged in reset, charged slowly by the source
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap <= 0;
      cs_above_min <= 1'h0;
      ss_above_thr <= 1'h0;
    end else begin
      if (ss_charge_on && cap < CAP_THR) cap <= cap + 1;
      ss_above_thr <= (cap >= CAP_THR) && !dim_low;
      cs_above_min <= drive_a || drive_b;
    end
  end
endmodule // ldsf_partner
`default_nettype wire

// >>> dv/ldsf_core_tb_top.sv
// testbench for the led drive core
`timescale 1ns/1ps
`default_nettype none
module ldsf_core_tb_top;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, dim_low = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic        cs_above_oc = 1'h0, cs_above_sc = 1'h0, vs_above_ov = 1'h0, sync_positive = 1'h0;
  logic        sync_below_uv = 1'h0, enable_above_2v = 1'h0, enable_above_3v = 1'h0, enable_above_4v = 1'h0;
  logic [3:0]  sync_cnt = 4'h0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, drive_a, drive_b, aux_drive, fault_n, ss_charge_on, ss_to_dimming, ov_clamp;
  wire         cs_above_min, ss_above_thr;
  wire         hready = hreadyout;
  int          n_mismatch = 0, checks_done = 0, na, nb, nx, ra;
  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    sync_cnt <= sync_cnt + 4'h1;
    if (sync_cnt == 4'hF) sync_positive <= ~sync_positive;
  end
  ldsf_core u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .cs_above_min, .cs_above_oc, .cs_above_sc, .vs_above_ov, .sync_positive,
    .sync_below_uv, .ss_above_thr, .enable_above_2v, .enable_above_3v, .enable_above_4v, .drive_a,
    .drive_b, .aux_drive, .fault_n, .ss_charge_on, .ss_to_dimming, .ov_clamp);
  ldsf_partner u_led (.hclk, .hresetn, .drive_a, .drive_b, .ss_charge_on, .dim_low, .cs_above_min, .ss_above_thr);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    q = hrdata;
  endtask
  task automatic rst();
    hresetn <= 1'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
  endtask
  // reset, short oscillator period, pwm mode, wait for soft start to end
  task automatic start();
    rst();
    bus(ldsf_pkg::OFS_PERIOD, 1'h1, 32'h4);
    bus(ldsf_pkg::OFS_LOOP, 1'h1, 32'h1);
    enable_above_2v <= 1'h1;
    enable_above_3v <= 1'h1;
    enable_above_4v <= 1'h0;
    for (int i = 0; i < 400 && ss_to_dimming !== 1'h1; i++) @(posedge hclk);
    repeat (12) @(posedge hclk);
  endtask
  task automatic meas(input int n);
    logic pa;
    na = 0;
    nb = 0;
    nx = 0;
    ra = 0;
    pa = drive_a;
    repeat (n) begin
      @(posedge hclk);
      na += drive_a;
      nb += drive_b;
      nx += aux_drive;
      ra += drive_a && !pa;
      pa = drive_a;
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst();
    bus(ldsf_pkg::OFS_PERIOD, 1'h0, 32'h0);
    chk("period", q, {16'h0, ldsf_pkg::PERIOD_RST});
    bus(ldsf_pkg::OFS_LOOP, 1'h0, 32'h0);
    chk("loop", q, {16'h0, ldsf_pkg::LOOP_RST});
    bus(ldsf_pkg::OFS_FCOUNT, 1'h0, 32'h0);
    chk("fcount", q, 32'h0);
    bus(8'h20, 1'h0, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    for (int m = 0; m < 4; m++) begin
      enable_above_2v <= m > 0;
      enable_above_3v <= m > 1;
      enable_above_4v <= m > 2;
      repeat (8) @(posedge hclk);
      bus(ldsf_pkg::OFS_STATUS, 1'h0, 32'h0);
      chk("mode", {30'h0, q[ldsf_pkg::ST_MODE+:2]}, 32'(m));
    end
    start();
    chk("charge", {31'h0, ss_charge_on}, 32'h0);
    bus(ldsf_pkg::OFS_STATUS, 1'h0, 32'h0);
    chk("run", {31'h0, q[ldsf_pkg::ST_RUN]}, 32'h1);
    meas(40);
    chk("pwm_a", na, 32'hA);
    chk("pwm_b", nb, 32'hA);
    chk("pwm_aux", nx, 32'hA);
    chk("pwm_freq", ra, 32'hA);
    dim_low <= 1'h1;
    repeat (8) @(posedge hclk);
    meas(20);
    chk("dim_off", na + nb + nx, 32'h0);
    dim_low <= 1'h0;
    enable_above_3v <= 1'h0;
    repeat (10) @(posedge hclk);
    meas(50);
    chk("res_freq", ra, 32'hA);
    bus(ldsf_pkg::OFS_LOOP, 1'h1, 32'h4);
    repeat (10) @(posedge hclk);
    meas(48);
    chk("res_freq_slow", ra, 32'h6);
    enable_above_3v <= 1'h1;
    enable_above_4v <= 1'h1;
    repeat (10) @(posedge hclk);
    meas(64);
    chk("sync_a_b", {30'h0, na != 0, nb != 0}, 32'h3);
    start();
    cs_above_oc <= 1'h1;
    repeat (60) @(posedge hclk);
    bus(ldsf_pkg::OFS_FCOUNT, 1'h0, 32'h0);
    chk("oc_counting", {31'h0, q != 32'h0}, 32'h1);
    cs_above_oc <= 1'h0;
    repeat (1100) @(posedge hclk);
    bus(ldsf_pkg::OFS_FCOUNT, 1'h0, 32'h0);
    chk("hold_clear", q, 32'h0);
    for (int s = 0; s < 3; s++) begin
      start();
      chk("fault_clear", {31'h0, fault_n}, 32'h1);
      cs_above_oc <= s == 0;
      vs_above_ov <= s == 1;
      sync_below_uv <= s == 2;
      for (int i = 0; i < 3000 && fault_n !== 1'h0; i++) @(posedge hclk);
      chk("clamp", {31'h0, ov_clamp}, {31'h0, s == 1});
      bus(ldsf_pkg::OFS_FCOUNT, 1'h0, 32'h0);
      chk("full_count", q, 32'h100);
      chk("count_fault", {31'h0, fault_n}, 32'h0);
      cs_above_oc <= 1'h0;
      vs_above_ov <= 1'h0;
      sync_below_uv <= 1'h0;
    end
    rst();
    cs_above_sc <= 1'h1;
    repeat (8) @(posedge hclk);
    cs_above_sc <= 1'h0;
    chk("sc_fault", {31'h0, fault_n}, 32'h0);
    bus(ldsf_pkg::OFS_STATUS, 1'h0, 32'h0);
    chk("sc_seen", {31'h0, q[ldsf_pkg::ST_SC]}, 32'h1);
    meas(300);
    chk("fault_drives", na + nb + nx, 32'h0);
    chk("fault_kept", {31'h0, fault_n}, 32'h0);
    end_sim();
  end
  initial begin
    repeat (30000) @(posedge hclk);
    n_mismatch++;
    end_sim();
  end
endmodule // ldsf_core_tb_top
`default_nettype wire
